//--- rtl/ofs_regs.svh
// Register offsets, field positions and reset values of the scheduling thresholds block
`ifndef OFS_REGS_SVH
`define OFS_REGS_SVH

`define OFS_ADDR_W            8
`define OFS_PS_OFF            8'h40
`define OFS_LSTH_OFF          8'h44
`define OFS_RHA_OFF           8'h48

`define OFS_REM_W             14
`define OFS_PS_MSB            13
`define OFS_PS_LSB            0
`define OFS_PS_RST            14'h0000
`define OFS_LSTH_MSB          11
`define OFS_LSTH_LSB          0
`define OFS_LSTH_RST          12'h628

`define OFS_PGT_MSB           31
`define OFS_PGT_LSB           24
`define OFS_PGT_RST           8'hFF
`define OFS_RHA_RSV_MSB       23
`define OFS_RHA_RSV_LSB       13
`define OFS_NOOC_BIT          12
`define OFS_NOOC_RST          1'b0
`define OFS_OCMODE_BIT        11
`define OFS_DEVTYPE_BIT       10
`define OFS_DEVTYPE_VAL       1'b0
`define OFS_NOPSW_BIT         9
`define OFS_NOPSW_RST         1'b0
`define OFS_PSWMODE_BIT       8
`define OFS_PSWMODE_RST       1'b1
// Overcurrent mode comes out of reset mirroring the power switching mode
`define OFS_OCMODE_RST        `OFS_PSWMODE_RST

`define OFS_ZERO_WORD         32'h0000_0000
`define OFS_ZERO_REM          14'h0000

`endif

//--- rtl/ofs_pkg.sv
// Types shared by the scheduling thresholds block
package ofs_pkg;

  typedef enum logic [1:0] {
    OFS_NONPERIODIC = 2'b00,
    OFS_DRAIN       = 2'b01,
    OFS_PERIODIC    = 2'b10
  } ofs_sched_t;

endpackage

//--- rtl/ofs_ge_cmp.sv
// Unsigned greater-or-equal comparator used for both frame thresholds
`timescale 1ns/1ps

module ofs_ge_cmp #(
  parameter int W = 14
) (
  // Operands
  input  wire logic [W-1:0] a,
  input  wire logic [W-1:0] b,
  // Result
  output wire logic         a_ge_b
);

  // Purely combinational so the decision uses the count of this very cycle
  assign a_ge_b = (a >= b);

endmodule

//--- rtl/ofs_sched.sv
// Periodic start, low-speed threshold and root hub descriptor A registers with frame scheduling
`timescale 1ns/1ps

`include "ofs_regs.svh"

// Contract
// - Periodic start field clears on reset
// - Periodic lists win once start point reached
// - Finish current control/bulk before interrupt list
// - Threshold gates committing low-speed packets
// - Start low-speed only if remaining >= threshold
// - Threshold register at 44h, resets 628h
// - Hardware never alters the threshold
// - Periodic start register decoded at 40h
// - Descriptor A at 48h, timing byte FFh
// - Descriptor A mode bits reset values
// - Reset values reflect built hub capability
// - Power switching mode decoding
// - Overcurrent reporting mode decoding
// - Device type bit reads zero
module ofs_sched #(
  parameter int              REM_W       = `OFS_REM_W,
  parameter logic [7:0]      PGT_RST     = `OFS_PGT_RST,
  parameter logic            NOOC_RST    = `OFS_NOOC_RST,
  parameter logic            NOPSW_RST   = `OFS_NOPSW_RST,
  parameter logic            PSWMODE_RST = `OFS_PSWMODE_RST,
  parameter logic            OCMODE_RST  = `OFS_OCMODE_RST
) (
  // Clock and reset
  input  wire logic            clk,
  input  wire logic            reset_n,
  // Register access, offsets from the base address
  input  wire logic            reg_wr,
  input  wire logic            reg_rd,
  input  wire logic [7:0]      reg_addr,
  input  wire logic [31:0]     reg_wdata,
  output logic      [31:0]     reg_rdata,
  output logic                 reg_rvalid,
  // Frame timer
  input  wire logic            frame_start,
  input  wire logic [REM_W-1:0] frame_remaining_count,
  // List processing
  input  wire logic            nonperiodic_busy,
  output wire logic            nonperiodic_grant,
  output wire logic            periodic_priority,
  output wire logic            periodic_grant,
  output wire logic            ls_start_ok,
  // Root hub power and overcurrent modes
  output wire logic            ports_always_powered,
  output wire logic            per_port_power,
  output wire logic            overcurrent_reporting,
  output wire logic            per_port_overcurrent
);

  logic [13:0]        periodic_start;
  logic [11:0]        low_speed_threshold_field;
  logic [7:0]         power_on_to_good_time;
  logic               no_overcurrent_protection;
  logic               overcurrent_report_mode;
  logic               no_power_switching;
  logic               power_switching_mode;
  ofs_pkg::ofs_sched_t state;
  ofs_pkg::ofs_sched_t next_state;

  // Address decode
  wire        sel_ps   = (reg_addr == `OFS_PS_OFF);
  wire        sel_lsth = (reg_addr == `OFS_LSTH_OFF);
  wire        sel_rha  = (reg_addr == `OFS_RHA_OFF);
  wire        wr_ps    = reg_wr && sel_ps;
  wire        wr_lsth  = reg_wr && sel_lsth;
  wire        wr_rha   = reg_wr && sel_rha;

  // Read views; reserved bits and the port count field read as zero
  wire [31:0] view_ps   = {18'h00000, periodic_start};
  wire [31:0] view_lsth = {20'h00000, low_speed_threshold_field};
  wire [31:0] view_rha  = {power_on_to_good_time, 11'h000, no_overcurrent_protection,
                           overcurrent_report_mode, `OFS_DEVTYPE_VAL, no_power_switching,
                           power_switching_mode, 8'h00};
  wire [31:0] next_rdata = sel_ps   ? view_ps   :
                           sel_lsth ? view_lsth :
                           sel_rha  ? view_rha  : `OFS_ZERO_WORD;

  // Register file; writes of reserved bits are dropped
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      periodic_start <= `OFS_PS_RST;
    end else if (wr_ps) begin
      periodic_start <= reg_wdata[`OFS_PS_MSB:`OFS_PS_LSB];
    end
  end

  // Only a software write changes the threshold
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      low_speed_threshold_field <= `OFS_LSTH_RST;
    end else if (wr_lsth) begin
      low_speed_threshold_field <= reg_wdata[`OFS_LSTH_MSB:`OFS_LSTH_LSB];
    end
  end

  // Reset values are parameters so a build can state its real capability
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      power_on_to_good_time     <= PGT_RST;
      no_overcurrent_protection <= NOOC_RST;
      overcurrent_report_mode   <= OCMODE_RST;
      no_power_switching        <= NOPSW_RST;
      power_switching_mode      <= PSWMODE_RST;
    end else if (wr_rha) begin
      power_on_to_good_time     <= reg_wdata[`OFS_PGT_MSB:`OFS_PGT_LSB];
      no_overcurrent_protection <= reg_wdata[`OFS_NOOC_BIT];
      overcurrent_report_mode   <= reg_wdata[`OFS_OCMODE_BIT];
      no_power_switching        <= reg_wdata[`OFS_NOPSW_BIT];
      power_switching_mode      <= reg_wdata[`OFS_PSWMODE_BIT];
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      reg_rdata  <= `OFS_ZERO_WORD;
      reg_rvalid <= 1'b0;
    end else begin
      reg_rvalid <= reg_rd;
      if (reg_rd) begin
        reg_rdata <= next_rdata;
      end
    end
  end

  // Mode decoding
  assign ports_always_powered  = no_power_switching;
  assign per_port_power        = !no_power_switching && power_switching_mode;
  assign overcurrent_reporting = !no_overcurrent_protection;
  assign per_port_overcurrent  = !no_overcurrent_protection && overcurrent_report_mode;

  // Threshold comparisons on the live down-counter
  wire ps_reached;
  wire ls_fits;

  ofs_ge_cmp #(.W(REM_W)) u_ps_cmp (
    .a      (REM_W'(periodic_start)),
    .b      (frame_remaining_count),
    .a_ge_b (ps_reached)
  );

  ofs_ge_cmp #(.W(REM_W)) u_ls_cmp (
    .a      (frame_remaining_count),
    .b      (REM_W'(low_speed_threshold_field)),
    .a_ge_b (ls_fits)
  );

  // Low-speed packets may only be committed while they still fit the frame
  assign ls_start_ok = ls_fits;

  // Scheduler; reaching the start point wins over a frame start in the same cycle
  always_comb begin
    next_state = state;
    unique case (state)
      ofs_pkg::OFS_NONPERIODIC: begin
        if (ps_reached) begin
          next_state = nonperiodic_busy ? ofs_pkg::OFS_DRAIN : ofs_pkg::OFS_PERIODIC;
        end
      end
      ofs_pkg::OFS_DRAIN: begin
        if (!nonperiodic_busy) begin
          next_state = ofs_pkg::OFS_PERIODIC;
        end
      end
      ofs_pkg::OFS_PERIODIC: begin
        next_state = ofs_pkg::OFS_PERIODIC;
      end
      default: begin
        next_state = ofs_pkg::OFS_NONPERIODIC;
      end
    endcase
    if (frame_start && !ps_reached) begin
      next_state = ofs_pkg::OFS_NONPERIODIC;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state <= ofs_pkg::OFS_NONPERIODIC;
    end else begin
      state <= next_state;
    end
  end

  // No new control or bulk work once the start point has been seen
  assign nonperiodic_grant = (state == ofs_pkg::OFS_NONPERIODIC) && !ps_reached;
  assign periodic_priority = (state != ofs_pkg::OFS_NONPERIODIC);
  assign periodic_grant    = (state == ofs_pkg::OFS_PERIODIC);

  // Checks
  property p_ps_reset;
    @(posedge clk) disable iff (!reset_n)
    $rose(reset_n) |-> (periodic_start == `OFS_PS_RST);
  endproperty
  a_ps_reset: assert property (p_ps_reset) else $error("periodic start not cleared by reset");

  property p_reach_go;
    @(posedge clk) disable iff (!reset_n)
    (state == ofs_pkg::OFS_NONPERIODIC && frame_remaining_count <= REM_W'(periodic_start) && !nonperiodic_busy)
      |=> (periodic_grant ##1 periodic_priority);
  endproperty
  a_reach_go: assert property (p_reach_go) else $error("periodic lists not prioritised at start point");

  property p_drain;
    @(posedge clk) disable iff (!reset_n)
    (state == ofs_pkg::OFS_DRAIN && nonperiodic_busy) |=> !periodic_grant && periodic_priority;
  endproperty
  a_drain: assert property (p_drain) else $error("interrupt list began during busy transaction");

  property p_grant_after_idle;
    @(posedge clk) disable iff (!reset_n)
    $rose(periodic_grant) |-> !$past(nonperiodic_busy) || $past(state == ofs_pkg::OFS_NONPERIODIC);
  endproperty
  a_grant_after_idle: assert property (p_grant_after_idle) else $error("grant while transaction busy");

  property p_ls_gate;
    @(posedge clk) disable iff (!reset_n)
    ls_start_ok |-> (frame_remaining_count >= REM_W'(low_speed_threshold_field));
  endproperty
  a_ls_gate: assert property (p_ls_gate) else $error("low-speed start below threshold");

  property p_lsth_reset;
    @(posedge clk) disable iff (!reset_n)
    $rose(reset_n) |-> (low_speed_threshold_field == `OFS_LSTH_RST);
  endproperty
  a_lsth_reset: assert property (p_lsth_reset) else $error("threshold reset value wrong");

  property p_lsth_stable;
    @(posedge clk) disable iff (!reset_n)
    !wr_lsth |=> $stable(low_speed_threshold_field);
  endproperty
  a_lsth_stable: assert property (p_lsth_stable) else $error("threshold changed without write");

  property p_ps_write;
    @(posedge clk) disable iff (!reset_n)
    (reg_wr && reg_addr == `OFS_PS_OFF) ##1 (reg_rd && reg_addr == `OFS_PS_OFF) ##1 1'b1
      |-> reg_rvalid && reg_rdata == {18'h00000, $past(reg_wdata[`OFS_PS_MSB:`OFS_PS_LSB], 2)};
  endproperty
  a_ps_write: assert property (p_ps_write) else $error("periodic start readback wrong");

  property p_rha_read;
    @(posedge clk) disable iff (!reset_n)
    (reg_rd && sel_rha) |=> reg_rvalid && reg_rdata[`OFS_RHA_RSV_MSB:`OFS_RHA_RSV_LSB] == 11'h000
      && reg_rdata[`OFS_DEVTYPE_BIT] == `OFS_DEVTYPE_VAL;
  endproperty
  a_rha_read: assert property (p_rha_read) else $error("descriptor reserved or type bit nonzero");

  property p_rha_reset;
    @(posedge clk) disable iff (!reset_n)
    $rose(reset_n) |-> power_on_to_good_time == PGT_RST && overcurrent_report_mode == power_switching_mode;
  endproperty
  a_rha_reset: assert property (p_rha_reset) else $error("descriptor reset values wrong");

  property p_power_mode;
    @(posedge clk) disable iff (!reset_n)
    per_port_power |-> !ports_always_powered && power_switching_mode;
  endproperty
  a_power_mode: assert property (p_power_mode) else $error("power mode decode wrong");

  c_drain: cover property (@(posedge clk) disable iff (!reset_n)
    state == ofs_pkg::OFS_DRAIN ##[1:20] periodic_grant);
  c_direct: cover property (@(posedge clk) disable iff (!reset_n)
    $rose(periodic_grant) && $past(state == ofs_pkg::OFS_NONPERIODIC));
  c_ls_refuse: cover property (@(posedge clk) disable iff (!reset_n) $fell(ls_start_ok));
  c_new_frame: cover property (@(posedge clk) disable iff (!reset_n)
    periodic_grant ##1 (state == ofs_pkg::OFS_NONPERIODIC));

endmodule

//--- bench/ofs_sched_bench.sv
// Self-checking bench for the frame scheduling thresholds block
`timescale 1ns/1ps

module ofs_sched_bench;
  // Clock and reset
  logic        clk;
  logic        reset_n;
  // Register access
  logic        reg_wr;
  logic        reg_rd;
  logic [7:0]  reg_addr;
  logic [31:0] reg_wdata;
  logic [31:0] reg_rdata;
  logic        reg_rvalid;
  // Frame timer and lists
  logic        frame_start;
  logic [13:0] count;
  logic        busy;
  logic        np_grant;
  logic        prio;
  logic        p_grant;
  logic        ls_ok;
  // Root hub modes
  logic        always_pwr;
  logic        pp_pwr;
  logic        oc_rep;
  logic        pp_oc;
  int          n_errors;
  int          checked;
  int          cycles;

  ofs_sched dut_u (
    .clk                   (clk),
    .reset_n               (reset_n),
    .reg_wr                (reg_wr),
    .reg_rd                (reg_rd),
    .reg_addr              (reg_addr),
    .reg_wdata             (reg_wdata),
    .reg_rdata             (reg_rdata),
    .reg_rvalid            (reg_rvalid),
    .frame_start           (frame_start),
    .frame_remaining_count (count),
    .nonperiodic_busy      (busy),
    .nonperiodic_grant     (np_grant),
    .periodic_priority     (prio),
    .periodic_grant        (p_grant),
    .ls_start_ok           (ls_ok),
    .ports_always_powered  (always_pwr),
    .per_port_power        (pp_pwr),
    .overcurrent_reporting (oc_rep),
    .per_port_overcurrent  (pp_oc)
  );

  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task automatic complete_run;
    if (n_errors == 0 && checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      n_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(negedge clk);
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(negedge clk);
    reg_wr = 1'b0;
  endtask

  // Read answer lands one cycle after the strobe edge
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    @(negedge clk);
    reg_rd = 1'b1;
    reg_addr = a;
    @(negedge clk);
    reg_rd = 1'b0;
    chk({31'h0, reg_rvalid}, 32'h1);
    chk(reg_rdata, exp);
  endtask

  task automatic chk_modes(input logic [3:0] exp);
    chk({28'h0, always_pwr, pp_pwr, oc_rep, pp_oc}, {28'h0, exp});
  endtask

  task automatic chk_sched(input logic [2:0] exp);
    chk({29'h0, np_grant, prio, p_grant}, {29'h0, exp});
  endtask

  task automatic test_reset_values;
    rd_chk(8'h40, 32'h0000_0000); // Cleared start
    rd_chk(8'h44, 32'h0000_0628); // Threshold default
    rd_chk(8'h48, 32'hFF00_0900); // Descriptor default
    chk_modes(4'h7); // Switched per port, per-port reports
    chk_sched(3'h4); // Idle frame
  endtask

  task automatic test_reg_access;
    wr(8'h40, 32'h0000_3FFF); // Reserved bits written as reset
    rd_chk(8'h40, 32'h0000_3FFF); // Whole field writable
    wr(8'h40, 32'h0000_3E67); // Typical start point
    rd_chk(8'h40, 32'h0000_3E67); // Typical value kept
    wr(8'h44, 32'h0000_0FFF); // Reserved bits written as reset
    rd_chk(8'h44, 32'h0000_0FFF); // Field only
    wr(8'h48, 32'hFF00_1F00); // Read-only type bit written high
    rd_chk(8'h48, 32'hFF00_1B00); // Type bit stays low
    chk_modes(4'h8); // Always powered, no protection
    wr(8'h48, 32'h1200_0800); // Port power-good waits lie outside this block
    rd_chk(8'h48, 32'h1200_0800); // Timing byte writable
    chk_modes(4'h3); // Ganged power, per-port reports
    wr(8'h4C, 32'h1234_5678);
    rd_chk(8'h4C, 32'h0000_0000); // Unmapped reads zero
    rd_chk(8'h40, 32'h0000_3E67); // Untouched by stray write
  endtask

  // Write then read on the very next edge
  task automatic test_back_to_back;
    @(negedge clk);
    reg_wr = 1'b1;
    reg_addr = 8'h40;
    reg_wdata = 32'h0000_1234;
    @(negedge clk);
    reg_wr = 1'b0;
    reg_rd = 1'b1;
    @(negedge clk);
    reg_rd = 1'b0;
    chk({31'h0, reg_rvalid}, 32'h1); // Answer one cycle after read
    chk(reg_rdata, 32'h0000_1234); // Read sees the write just made
    @(negedge clk);
    chk({31'h0, reg_rvalid}, 32'h0); // Answer stands one cycle only
    chk(reg_rdata, 32'h0000_1234); // Data held until next read
  endtask

  // Reset in mid-run restores every documented value
  task automatic test_mid_reset;
    wr(8'h44, 32'h0000_0300); // Reserved bits written as reset
    @(negedge clk);
    reset_n = 1'b0;
    @(negedge clk);
    reset_n = 1'b1;
    chk_sched(3'h4); // Scheduler idle after reset
    rd_chk(8'h40, 32'h0000_0000); // Start point cleared again
    rd_chk(8'h44, 32'h0000_0628); // Threshold default again
    rd_chk(8'h48, 32'hFF00_0900); // Descriptor default again
  endtask

  // Gate is combinational on the live count
  task automatic test_ls_gate;
    wr(8'h44, 32'h0000_0200); // Threshold chosen with setup margin
    @(negedge clk);
    count = 14'h01FF;
    #1 chk({31'h0, ls_ok}, 32'h0); // Below threshold
    @(negedge clk);
    count = 14'h0200;
    #1 chk({31'h0, ls_ok}, 32'h1); // Equal starts
    @(negedge clk);
    count = 14'h0201;
    #1 chk({31'h0, ls_ok}, 32'h1); // Above starts
    @(negedge clk);
    frame_start = 1'b1;
    count = 14'h3000;
    @(negedge clk);
    frame_start = 1'b0;
    rd_chk(8'h44, 32'h0000_0200); // Hardware keeps value
  endtask

  task automatic test_sched;
    wr(8'h40, 32'h0000_0100);
    @(negedge clk);
    frame_start = 1'b1;
    count = 14'h0300;
    busy = 1'b0;
    @(negedge clk);
    frame_start = 1'b0;
    count = 14'h0101;
    #1 chk_sched(3'h4); // Above start point
    @(negedge clk);
    count = 14'h0100;
    busy = 1'b1;
    #1 chk_sched(3'h0); // Non-periodic refused at start point
    repeat (3) begin
      @(negedge clk);
      count = count - 14'h1;
      chk_sched(3'h2); // Draining current transaction
    end
    busy = 1'b0;
    @(negedge clk);
    chk_sched(3'h3); // Interrupt list after drain
    frame_start = 1'b1;
    count = 14'h0300;
    @(negedge clk);
    frame_start = 1'b0;
    chk_sched(3'h4); // New frame back to control and bulk
    count = 14'h0100;
    @(negedge clk);
    chk_sched(3'h3); // Idle at start point grants at once
  endtask

  // Whole run needs about seventy cycles
  always @(posedge clk) begin
    cycles++;
    if (cycles == 1000) begin
      n_errors++;
      complete_run();
    end
  end

  initial begin
    n_errors = 0;
    checked = 0;
    cycles = 0;
    reset_n = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 32'h0000_0000;
    frame_start = 1'b0;
    count = 14'h3FFF;
    busy = 1'b0;
    repeat (3) @(posedge clk);
    @(negedge clk);
    reset_n = 1'b1;
    test_reset_values();
    test_reg_access();
    test_back_to_back();
    test_ls_gate();
    test_sched();
    test_mid_reset();
    complete_run();
  end
endmodule
